// ### gpio_port_pkg.sv
// constants, carrier structs and the owner enum for the shared eight-bit port
package gpio_port_pkg;

  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LATCH    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MEMCTL   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SPCTL    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HOST_WR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;

  // field positions
  localparam int EXT_BUS_DISABLE_BIT = 7;
  localparam int SLAVE_MODE_BIT      = 4;
  localparam int STAT_OWNER_LSB      = 0;
  localparam int STAT_HOST_WR_BIT    = 2;

  // writable bits of the control registers
  localparam logic [PORT_W-1:0] MEMCTL_MASK = 8'h80;
  localparam logic [PORT_W-1:0] SPCTL_MASK  = 8'h10;

  // values after reset
  localparam logic [PORT_W-1:0] RST_DIR    = 8'hFF;
  localparam logic [PORT_W-1:0] RST_LATCH  = 8'h00;
  localparam logic [PORT_W-1:0] RST_MEMCTL = 8'h80;
  localparam logic [PORT_W-1:0] RST_SPCTL  = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // which function owns the pins
  typedef enum logic [1:0] {
    OWN_PORT  = 2'b00,
    OWN_SLAVE = 2'b01,
    OWN_EXT   = 2'b11
  } owner_e;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

endpackage

// ### bidir_port_with_bus_mux.sv
// eight-bit bidirectional port shared with external bus and host parallel port
`timescale 1ns/1ps

module bidir_port_with_bus_mux #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire gpio_port_pkg::axi_req_s         axi_req,
  output      gpio_port_pkg::axi_rsp_s         axi_rsp,
  input  wire logic [gpio_port_pkg::PORT_W-1:0] pin_in,
  output      logic [gpio_port_pkg::PORT_W-1:0] pin_out,
  output      logic [gpio_port_pkg::PORT_W-1:0] pin_oe,
  input  wire logic [gpio_port_pkg::PORT_W-1:0] ext_bus_ad_out,
  input  wire logic                            ext_bus_drive,
  output      logic [gpio_port_pkg::PORT_W-1:0] ext_bus_data_in,
  input  wire logic                            host_read_active,
  input  wire logic                            host_write_active
);
  import gpio_port_pkg::*;

  typedef struct packed {
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] memctl;
    logic [PORT_W-1:0] spctl;
    logic [PORT_W-1:0] host_wr_data;
    logic              host_wr_flag;
    logic [PORT_W-1:0] pin_s1;
    logic [PORT_W-1:0] pin_s2;
    logic [PORT_W-1:0] pin_s3;
    logic [PORT_W-1:0] pin_filt;
    logic [2:0]        hrd_s;
    logic              hrd_filt;
    logic [2:0]        hwr_s;
    logic              hwr_filt;
    owner_e            owner;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic [PORT_W-1:0] ext_data_in;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [PORT_W-1:0] wdata;
    logic              wstrb0;
    axi_rsp_s          rsp;
  } state_s;

  state_s st;
  state_s next_st;

  // register outputs straight from the state
  // every top-level output comes from a flip-flop, so the pins never glitch
  assign axi_rsp         = st.rsp;
  assign pin_out         = st.pin_out;
  assign pin_oe          = st.pin_oe;
  assign ext_bus_data_in = st.ext_data_in;

  // next-state logic: synchronisers, pin ownership, bus slave
  always_comb
  begin
    logic [PORT_W-1:0] agree;
    logic              ext_en;
    logic              wr_go;
    logic              wr_ok;
    logic [PORT_W-1:0] rd_val;
    logic              rd_ok;
    agree   = '0;
    ext_en  = 1'b0;
    wr_go   = 1'b0;
    wr_ok   = 1'b0;
    rd_val  = '0;
    rd_ok   = 1'b0;
    next_st = st;

    // three-stage sampling; a change counts once stages two and three agree
    // pins and host strobes are asynchronous; the first stage may go metastable
    // a level that differs between stages two and three keeps the last filtered value
    next_st.pin_s1   = pin_in;
    next_st.pin_s2   = st.pin_s1;
    next_st.pin_s3   = st.pin_s2;
    agree            = ~(st.pin_s2 ^ st.pin_s3);
    next_st.pin_filt = (st.pin_filt & ~agree) | (st.pin_s3 & agree);
    next_st.hrd_s    = {st.hrd_s[1:0], host_read_active};
    if (st.hrd_s[1] == st.hrd_s[2])
    begin
      next_st.hrd_filt = st.hrd_s[2];
    end
    next_st.hwr_s    = {st.hwr_s[1:0], host_write_active};
    if (st.hwr_s[1] == st.hwr_s[2])
    begin
      next_st.hwr_filt = st.hwr_s[2];
    end

    // pin owner by fixed priority: external bus, then slave port, then port
    // owner is registered, so a control write never switches drivers mid-cycle
    // on the small variant the bus disable bit is kept but has no effect
    ext_en = HAS_EXT_BUS && !st.memctl[EXT_BUS_DISABLE_BIT];
    if (ext_en)
    begin
      next_st.owner = OWN_EXT;
    end
    else if (st.spctl[SLAVE_MODE_BIT])
    begin
      next_st.owner = OWN_SLAVE;
    end
    else
    begin
      next_st.owner = OWN_PORT;
    end

    // pin drivers from the current owner
    // host read drives every pin, host write releases them all; direction ignored
    case (st.owner)
      OWN_EXT:
      begin
        next_st.pin_out     = ext_bus_ad_out;
        next_st.pin_oe      = {PORT_W{ext_bus_drive}};
        next_st.ext_data_in = st.pin_filt;
      end
      OWN_SLAVE:
      begin
        next_st.pin_out = st.latch;
        next_st.pin_oe  = {PORT_W{st.hrd_filt && !st.hwr_filt}};
      end
      default:
      begin
        next_st.pin_out = st.latch;
        next_st.pin_oe  = ~st.dir;
      end
    endcase

    // host write ends: pins taken as write data, flag set
    // the pin filter and the strobe filter have the same latency, so the byte taken
    // is the one on the pins in the last cycle the write strobe was high
    if (st.owner == OWN_SLAVE && !next_st.hwr_filt && st.hwr_filt)
    begin
      next_st.host_wr_data = st.pin_filt;
    end

    // write address and data channels, taken in either order
    // a taken channel drops its ready until the response is accepted
    if (axi_req.awvalid && st.rsp.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = axi_req.wdata[PORT_W-1:0];
      next_st.wstrb0 = axi_req.wstrb[0];
    end
    if (st.rsp.bvalid && axi_req.bready)
    begin
      next_st.rsp.bvalid = 1'b0;
    end

    // register write once both halves are held
    // the response waits until the previous one has been accepted
    // only byte lane 0 carries register bits; other lanes are ignored
    wr_go = st.aw_got && st.w_got && !st.rsp.bvalid;
    if (wr_go)
    begin
      wr_ok = 1'b1;
      case (st.awaddr)
        OFS_PIN_DATA, OFS_LATCH:
        begin
          if (st.wstrb0)
          begin
            next_st.latch = st.wdata;
          end
        end
        OFS_DIR:
        begin
          if (st.wstrb0)
          begin
            next_st.dir = st.wdata;
          end
        end
        OFS_MEMCTL:
        begin
          if (st.wstrb0)
          begin
            next_st.memctl = st.wdata & MEMCTL_MASK;
          end
        end
        OFS_SPCTL:
        begin
          if (st.wstrb0)
          begin
            next_st.spctl = st.wdata & SPCTL_MASK;
          end
        end
        OFS_HOST_WR:
        begin
          wr_ok = 1'b1; // read only, write ignored
        end
        OFS_STATUS:
        begin
          if (st.wstrb0 && st.wdata[STAT_HOST_WR_BIT])
          begin
            next_st.host_wr_flag = 1'b0; // write one clears
          end
        end
        default:
        begin
          wr_ok = 1'b0;
        end
      endcase
      next_st.aw_got     = 1'b0;
      next_st.w_got      = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // a host write ending in the clear cycle still sets the flag
    // placed after the register write so the set overrides a clear
    if (st.owner == OWN_SLAVE && !next_st.hwr_filt && st.hwr_filt)
    begin
      next_st.host_wr_flag = 1'b1;
    end

    // read channel
    // read data is registered with the response and stands until rready
    if (st.rsp.rvalid && axi_req.rready)
    begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready)
    begin
      rd_ok = 1'b1;
      case (axi_req.araddr)
        OFS_PIN_DATA: rd_val = st.pin_filt;
        OFS_LATCH:    rd_val = st.latch;
        OFS_DIR:      rd_val = st.dir;
        OFS_MEMCTL:   rd_val = st.memctl;
        OFS_SPCTL:    rd_val = st.spctl;
        OFS_HOST_WR:  rd_val = st.host_wr_data;
        OFS_STATUS:
        begin
          // owner code and host write flag share the status word
          rd_val                                  = '0;
          rd_val[STAT_OWNER_LSB+1:STAT_OWNER_LSB] = st.owner;
          rd_val[STAT_HOST_WR_BIT]                = st.host_wr_flag;
        end
        default:
        begin
          rd_ok  = 1'b0;
          rd_val = '0;
        end
      endcase
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata  = {24'h00_0000, rd_val};
      next_st.rsp.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // ready only while a slot is free
    // taken from the next state so a freed slot reopens on the following edge
    next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
    next_st.rsp.wready  = !next_st.w_got && !next_st.rsp.bvalid;
    next_st.rsp.arready = !next_st.rsp.rvalid;
  end

  // state register with synchronous reset
  // control registers load their reset values; all other state clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st        <= '0;
      st.dir    <= RST_DIR;
      st.latch  <= RST_LATCH;
      st.memctl <= RST_MEMCTL;
      st.spctl  <= RST_SPCTL;
      st.owner  <= OWN_PORT;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// ### pin_partner.sv
// far side of the pins: outside host or memory, with pull-ups
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic       far_drive,
  input  wire logic [7:0] far_data,
  output      logic [7:0] pin_in
);
  // both sides driving shows as unknown; an idle pin floats up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_in[i] = pin_oe[i] ? (far_drive ? 1'bx : pin_out[i])
                            : (far_drive ? far_data[i] : 1'b1);
    end
  end
endmodule

// ### bidir_port_monitor.sv
// assertion checker for the shared port
`timescale 1ns/1ps
module bidir_port_monitor #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire gpio_port_pkg::axi_req_s axi_req,
  input wire gpio_port_pkg::axi_rsp_s axi_rsp,
  input wire logic [7:0]              pin_in,
  input wire logic [7:0]              pin_out,
  input wire logic [7:0]              pin_oe,
  input wire logic [7:0]              ext_bus_ad_out,
  input wire logic                    ext_bus_drive,
  input wire logic [7:0]              ext_bus_data_in
);
  import gpio_port_pkg::*;
  logic ext_on;
  logic wr_go;
  logic rd_go;
  // handshakes on the register bus
  assign wr_go = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  assign rd_go = axi_req.arvalid && axi_rsp.arready;
  // external bus ownership followed from control writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_on <= 1'b0;
    else if (wr_go && axi_req.awaddr == OFS_MEMCTL)
      ext_on <= HAS_EXT_BUS && !axi_req.wdata[EXT_BUS_DISABLE_BIT];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ext_held;
    ext_on [*6];
  endsequence
  property p_rst_idle;
    $rose(aresetn) |-> pin_oe == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins driven after reset");
  property p_wr_lat;
    wr_go |=> ##1 axi_rsp.bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("late write response");
  property p_b_once;
    axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_rd_lat;
    rd_go |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late or wide read data");
  property p_ar_block;
    axi_rsp.rvalid |-> !axi_rsp.arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_slverr;
    rd_go && axi_req.araddr > OFS_STATUS |=> axi_rsp.rresp == RESP_SLVERR;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  property p_ext_drive;
    s_ext_held ##0 ext_bus_drive [*2] |-> pin_oe == 8'hFF && pin_out == $past(ext_bus_ad_out);
  endproperty
  a_ext_drive: assert property (p_ext_drive) else $error("bus byte not on pins");
  property p_ext_sample;
    s_ext_held ##0 $stable(pin_in) [*6] |-> ext_bus_data_in == pin_in;
  endproperty
  a_ext_sample: assert property (p_ext_sample) else $error("bus sample wrong");
endmodule
bind bidir_port_with_bus_mux bidir_port_monitor #(.HAS_EXT_BUS(HAS_EXT_BUS)) bidir_port_monitor_i (
  .aclk, .aresetn, .axi_req, .axi_rsp, .pin_in, .pin_out, .pin_oe, .ext_bus_ad_out,
  .ext_bus_drive, .ext_bus_data_in);

// ### bidir_port_with_bus_mux_tb_top.sv
// self-checking bench for the shared eight-bit port
`timescale 1ns/1ps
module bidir_port_with_bus_mux_tb_top;
  import gpio_port_pkg::*;
  logic       aclk, aresetn, ext_bus_drive, host_read_active, host_write_active, far_drive;
  logic [7:0] pin_in, pin_out, pin_oe, ext_bus_ad_out, ext_bus_data_in, far_data;
  axi_req_s   axi_req;
  axi_rsp_s   axi_rsp;
  logic [7:0] small_out, small_oe, small_ext_in;
  axi_rsp_s   small_rsp;
  int         err_count = 0, n_checks = 0, cyc = 0;
  // 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  bidir_port_with_bus_mux bidir_port_with_bus_mux_i (.aclk, .aresetn, .axi_req, .axi_rsp,
    .pin_in, .pin_out, .pin_oe, .ext_bus_ad_out, .ext_bus_drive, .ext_bus_data_in,
    .host_read_active, .host_write_active);
  pin_partner pin_partner_i (.pin_out, .pin_oe, .far_drive, .far_data, .pin_in);
  // small variant without external bus, same register traffic in lock step
  bidir_port_with_bus_mux #(.HAS_EXT_BUS(1'b0)) bidir_port_with_bus_mux_small_i (.aclk,
    .aresetn, .axi_req, .axi_rsp(small_rsp), .pin_in, .pin_out(small_out), .pin_oe(small_oe),
    .ext_bus_ad_out, .ext_bus_drive, .ext_bus_data_in(small_ext_in), .host_read_active,
    .host_write_active);
  // compare one result
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= {24'h00_0000, d};
    axi_req.bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end
    while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    chk("bresp", r, axi_rsp.bresp);
  endtask
  // bus read with expected data and response
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end
    while (!axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
    chk(nm, e, axi_rsp.rdata);
    chk("rresp", r, axi_rsp.rresp);
  endtask
  // report and stop
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      close_out();
    end
  end
  // test sequence
  initial
  begin
    aresetn = 1'b0;
    axi_req = '0;
    axi_req.wstrb = 4'hF;
    {ext_bus_drive, host_read_active, host_write_active, far_drive} = 4'h0;
    {ext_bus_ad_out, far_data} = 16'h0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe", 8'h00, pin_oe);
    rd("dir", OFS_DIR, 32'h0000_00FF, RESP_OKAY);
    rd("memctl", OFS_MEMCTL, 32'h0000_0080, RESP_OKAY);
    rd("spctl", OFS_SPCTL, 32'h0000_0000, RESP_OKAY);
    rd("gap", 8'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(8'h1C, 8'hFF, RESP_SLVERR);
    wr(OFS_LATCH, 8'hA5);
    wr(OFS_DIR, 8'h0F);
    repeat (6) @(posedge aclk);
    chk("oe", 8'hF0, pin_oe);
    chk("out", 8'hA0, pin_out & pin_oe);
    rd("latch", OFS_LATCH, 32'h0000_00A5, RESP_OKAY);
    rd("pins", OFS_PIN_DATA, 32'h0000_00AF, RESP_OKAY);
    wr(OFS_PIN_DATA, 8'h3C);
    rd("latch", OFS_LATCH, 32'h0000_003C, RESP_OKAY);
    wr(OFS_SPCTL, 8'h10);
    wr(OFS_MEMCTL, 8'h00);
    ext_bus_ad_out <= 8'h5A;
    ext_bus_drive <= 1'b1;
    host_read_active <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("ext_oe", 8'hFF, pin_oe);
    chk("ext_out", 8'h5A, pin_out);
    chk("small_out", 8'h3C, small_out);
    rd("owner", OFS_STATUS, 32'h0000_0003, RESP_OKAY);
    chk("small_owner", 32'h0000_0001, small_rsp.rdata);
    ext_bus_drive <= 1'b0;
    repeat (4) @(posedge aclk);
    far_drive <= 1'b1;
    far_data <= 8'h96;
    repeat (8) @(posedge aclk);
    chk("ext_in", 8'h96, ext_bus_data_in);
    chk("small_ext_in", 8'h00, small_ext_in);
    far_drive <= 1'b0;
    wr(OFS_MEMCTL, 8'h80);
    repeat (8) @(posedge aclk);
    chk("rd_oe", 8'hFF, pin_oe);
    chk("rd_out", 8'h3C, pin_out);
    host_read_active <= 1'b0;
    repeat (8) @(posedge aclk);
    far_drive <= 1'b1;
    far_data <= 8'hC3;
    host_write_active <= 1'b1;
    repeat (8) @(posedge aclk);
    host_write_active <= 1'b0;
    repeat (8) @(posedge aclk);
    far_drive <= 1'b0;
    wr(OFS_HOST_WR, 8'h00);
    rd("host_wr", OFS_HOST_WR, 32'h0000_00C3, RESP_OKAY);
    rd("status", OFS_STATUS, 32'h0000_0005, RESP_OKAY);
    wr(OFS_STATUS, 8'h04);
    rd("status_clr", OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    wr(OFS_SPCTL, 8'h00);
    repeat (6) @(posedge aclk);
    chk("oe", 8'hF0, pin_oe);
    close_out();
  end
endmodule
